// [src/lsd_top.sv]
`timescale 1ns/100ps
`include "lsd_defs.svh"
module lsd_top
    import lsd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic [7:0] i_shift_count,
    output logic o_byte_ready,
    output logic o_valid,
    output logic o_done,
    output logic o_busy,
    output logic o_illegal,
    output lsd_op_t o_op,
    output lsd_form_t o_form,
    output logic [2:0] o_shift_kind,
    output logic o_word,
    output logic o_dir_to_reg,
    output logic o_mem,
    output logic o_write_result,
    output logic o_flags_only,
    output logic [2:0] o_reg_field,
    output logic [2:0] o_rm_field,
    output logic [15:0] o_disp,
    output logic [15:0] o_imm,
    output logic [7:0] o_shift_amount,
    output logic [8:0] o_cycles
);
    // ***************************************************
    // state
    // ***************************************************
    lsd_state_t state_reg;
    lsd_state_t state_next;
    logic [7:0] opcode_reg;
    logic [7:0] modrm_reg;
    logic [15:0] disp_reg;
    logic [15:0] imm_reg;
    logic [1:0] left_reg;
    logic [1:0] left_next;
    logic hi_reg;
    logic [8:0] cnt_reg;
    lsd_dec_if dif();
    lsd_field_decode u_dec (.d(dif.dec));
    lsd_cycle_calc u_calc (.c(dif.calc));
    // ***************************************************
    // decode steering
    // ***************************************************
    wire st_idle = state_reg == ST_IDLE;
    wire st_modrm = state_reg == ST_MODRM;
    wire st_disp = state_reg == ST_DISP;
    wire st_imm = state_reg == ST_IMM;
    wire st_load = state_reg == ST_LOAD;
    wire st_exec = state_reg == ST_EXEC;
    wire take = i_byte_valid & o_byte_ready;
    wire [7:0] modrm_cur = st_modrm ? i_byte : modrm_reg;
    wire [1:0] mod_cur = modrm_cur[`LSD_MOD_FLD];
    wire direct = mod_cur == `LSD_MOD_NODISP && modrm_cur[`LSD_RM_FLD] == `LSD_RM_DIRECT;
    wire [1:0] disp_n = (mod_cur == `LSD_MOD_D8) ? `LSD_LEFT_ONE :
        (mod_cur == `LSD_MOD_D16 || direct) ? `LSD_LEFT_TWO : `LSD_LEFT_NONE;
    wire imm_after = dif.imm_bytes != `LSD_LEFT_NONE;
    wire bad_byte = take & ((st_idle & ~dif.known) | (st_modrm & dif.illegal_mid));
    wire last_cnt = cnt_reg == `LSD_CYC_LAST;
    wire fetch_next = state_next == ST_IDLE || state_next == ST_MODRM ||
        state_next == ST_DISP || state_next == ST_IMM;
    wire stay = state_next == state_reg;
    wire write_res = dif.op != OP_TEST;
    assign dif.opcode = st_idle ? i_byte : opcode_reg;
    assign dif.modrm = modrm_cur;
    assign dif.mem = modrm_reg[`LSD_MOD_FLD] != `LSD_MOD_REG;
    assign dif.n = (dif.form == FORM_SH_IMM) ? imm_reg[`LSD_LO_BYTE] : i_shift_count;
    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        state_next = state_reg;
        left_next = left_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take && dif.known) begin
                    if (dif.needs_modrm) begin
                        state_next = ST_MODRM;
                    end else begin
                        state_next = ST_IMM;
                        left_next = dif.imm_bytes;
                    end
                end
            end
            ST_MODRM: begin
                if (take) begin
                    if (dif.illegal_mid) begin
                        state_next = ST_IDLE;
                    end else if (disp_n != `LSD_LEFT_NONE) begin
                        state_next = ST_DISP;
                        left_next = disp_n;
                    end else if (imm_after) begin
                        state_next = ST_IMM;
                        left_next = dif.imm_bytes;
                    end else begin
                        state_next = ST_LOAD;
                    end
                end
            end
            ST_DISP: begin
                if (take) begin
                    if (left_reg == `LSD_LEFT_ONE) begin
                        state_next = imm_after ? ST_IMM : ST_LOAD;
                        left_next = dif.imm_bytes;
                    end else begin
                        left_next = left_reg - `LSD_LEFT_ONE;
                    end
                end
            end
            ST_IMM: begin
                if (take) begin
                    if (left_reg == `LSD_LEFT_ONE) begin
                        state_next = ST_LOAD;
                    end else begin
                        left_next = left_reg - `LSD_LEFT_ONE;
                    end
                end
            end
            ST_LOAD: begin
                state_next = ST_EXEC;
            end
            ST_EXEC: begin
                if (last_cnt) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end
    // ***************************************************
    // byte capture
    // ***************************************************
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            left_reg <= `LSD_LEFT_NONE;
            hi_reg <= 1'b0;
            opcode_reg <= 8'h00;
            modrm_reg <= 8'h00;
            disp_reg <= 16'h0000;
            imm_reg <= 16'h0000;
            o_byte_ready <= 1'b1;
        end else if (i_ce) begin
            state_reg <= state_next;
            left_reg <= left_next;
            o_byte_ready <= fetch_next;
            hi_reg <= take && stay && (st_disp || st_imm) ? 1'b1 : (stay ? hi_reg : 1'b0);
            if (take && st_idle) begin
                opcode_reg <= i_byte;
                disp_reg <= 16'h0000;
                imm_reg <= 16'h0000;
            end
            if (take && st_modrm) begin
                modrm_reg <= i_byte;
            end
            if (take && st_disp && !hi_reg) disp_reg[`LSD_LO_BYTE] <= i_byte;
            if (take && st_disp && hi_reg) disp_reg[`LSD_HI_BYTE] <= i_byte;
            if (take && st_imm && !hi_reg) imm_reg[`LSD_LO_BYTE] <= i_byte;
            if (take && st_imm && hi_reg) imm_reg[`LSD_HI_BYTE] <= i_byte;
        end
    end
    // ***************************************************
    // result and timing
    // ***************************************************
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= 9'h000;
            o_valid <= 1'b0;
            o_done <= 1'b0;
            o_busy <= 1'b0;
            o_illegal <= 1'b0;
            o_op <= OP_NONE;
            o_form <= FORM_REG_RM;
            o_shift_kind <= 3'h0;
            o_word <= 1'b0;
            o_dir_to_reg <= 1'b0;
            o_mem <= 1'b0;
            o_write_result <= 1'b0;
            o_flags_only <= 1'b0;
            o_reg_field <= 3'h0;
            o_rm_field <= 3'h0;
            o_disp <= 16'h0000;
            o_imm <= 16'h0000;
            o_shift_amount <= 8'h00;
            o_cycles <= 9'h000;
        end else if (i_ce) begin
            o_valid <= st_load;
            o_done <= st_exec && last_cnt;
            o_illegal <= bad_byte;
            if (st_load) begin
                cnt_reg <= dif.cycles;
                o_busy <= 1'b1;
                o_op <= dif.op;
                o_form <= dif.form;
                o_shift_kind <= modrm_reg[`LSD_REG_FLD];
                o_word <= opcode_reg[`LSD_W_BIT];
                o_dir_to_reg <= dif.dir_to_reg;
                o_mem <= dif.mem;
                o_write_result <= write_res;
                o_flags_only <= ~write_res;
                o_reg_field <= modrm_reg[`LSD_REG_FLD];
                o_rm_field <= modrm_reg[`LSD_RM_FLD];
                o_disp <= disp_reg;
                o_imm <= imm_reg;
                o_shift_amount <= dif.n;
                o_cycles <= dif.cycles;
            end else if (st_exec) begin
                cnt_reg <= cnt_reg - `LSD_CYC_LAST;
                o_busy <= ~last_cnt;
            end
        end
    end
    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn || !i_ce);
    sequence s_busy_two;
        o_busy [*2] ##1 (o_done && !o_busy);
    endsequence
    sequence s_done_drop;
        !o_busy ##1 !o_done;
    endsequence
    chk_sh1_cost: assert property (o_valid && o_form == FORM_SH_ONE |->
        o_cycles == (o_mem ? `LSD_CYC_SH1_MEM : `LSD_CYC_SH1_REG))
        else $error("shift by one cost wrong");
    chk_shcnt_cost: assert property (o_valid && o_form == FORM_SH_CNT |->
        o_cycles == (o_mem ? `LSD_CYC_SHN_MEM : `LSD_CYC_SHN_REG) + {1'b0, o_shift_amount})
        else $error("count register shift cost wrong");
    chk_shimm_count: assert property (o_valid && o_form == FORM_SH_IMM |->
        o_shift_amount == o_imm[`LSD_LO_BYTE] && o_imm[`LSD_HI_BYTE] == 8'h00)
        else $error("immediate shift count wrong");
    chk_kind_legal: assert property (o_valid && o_op == OP_SHIFT |->
        o_shift_kind != 3'h4 && o_shift_kind != 3'h6)
        else $error("reserved shift kind accepted");
    chk_rm_cost: assert property (o_valid && o_form == FORM_REG_RM |->
        o_cycles == (o_mem ? `LSD_CYC_RM_MEM : `LSD_CYC_RM_REG))
        else $error("register operand cost wrong");
    chk_grp_imm_cost: assert property (o_valid && o_form == FORM_IMM_RM &&
        o_op != OP_TEST |->
        o_cycles == (o_mem ? `LSD_CYC_IMM_MEM : `LSD_CYC_IMM_REG))
        else $error("immediate logic cost wrong");
    chk_acc_cost: assert property (o_valid && o_form == FORM_ACC |->
        o_cycles == (o_word ? `LSD_CYC_ACC_W : `LSD_CYC_ACC_B) &&
        (o_word || o_imm[`LSD_HI_BYTE] == 8'h00))
        else $error("accumulator form cost wrong");
    chk_test_flags: assert property (o_valid && o_op == OP_TEST |->
        !o_write_result && o_flags_only)
        else $error("test form writes a result");
    chk_not_cost: assert property (o_valid && o_op == OP_NOT |->
        o_cycles == `LSD_CYC_NOT && o_write_result)
        else $error("invert cost wrong");
    chk_busy_span: assert property (o_valid && o_cycles == `LSD_CYC_SH1_REG |->
        s_busy_two)
        else $error("busy span wrong");
    chk_dir_word: assert property (o_valid && o_form == FORM_REG_RM &&
        o_op != OP_TEST |->
        o_dir_to_reg == opcode_reg[`LSD_D_BIT] && o_word == opcode_reg[`LSD_W_BIT])
        else $error("direction or width wrong");
    chk_shimm_cost: assert property (o_valid && o_form == FORM_SH_IMM |->
        o_cycles == (o_mem ? `LSD_CYC_SHN_MEM : `LSD_CYC_SHN_REG) + {1'b0, o_shift_amount})
        else $error("count byte cost wrong");
    chk_tsti_cost: assert property (o_valid && o_form == FORM_IMM_RM &&
        o_op == OP_TEST |->
        o_cycles == (o_mem ? `LSD_CYC_TSTI_MEM : `LSD_CYC_IMM_REG))
        else $error("immediate test cost wrong");
    chk_flags_pair: assert property (o_valid |->
        o_write_result != o_flags_only)
        else $error("result and flags clash");
    chk_imm_high: assert property (o_valid && !o_word &&
        (o_form == FORM_ACC || o_form == FORM_IMM_RM) |->
        o_imm[`LSD_HI_BYTE] == 8'h00)
        else $error("byte data has a high byte");
    chk_rm_ops: assert property (o_valid && o_form == FORM_REG_RM |->
        o_op == OP_AND || o_op == OP_OR || o_op == OP_XOR || o_op == OP_TEST)
        else $error("register form operation wrong");
    chk_acc_dir: assert property (o_valid && o_form == FORM_ACC |->
        !o_dir_to_reg)
        else $error("accumulator direction set");
    chk_shift_form: assert property (o_valid && o_op == OP_SHIFT |->
        o_form == FORM_SH_ONE || o_form == FORM_SH_CNT || o_form == FORM_SH_IMM)
        else $error("shift form wrong");
    chk_not_form: assert property (o_valid && o_op == OP_NOT |->
        o_form == FORM_UNARY && !o_flags_only)
        else $error("invert form wrong");
    chk_done_pulse: assert property (o_done |->
        s_done_drop)
        else $error("done pulse too long");
    chk_busy_ready: assert property (o_busy |->
        !o_byte_ready)
        else $error("byte taken while busy");
endmodule // lsd_top

// [src/lsd_defs.svh]
// Operation
// - First byte 1101000w plus an operand byte shifts or rotates by one, 2 cycles register, 15 memory.
// - First byte 1101001w shifts or rotates by the count register value n, 5+n register, 17+n memory.
// - First byte 1100000w takes n from a count byte after the operand byte, 5+n or 17+n cycles.
// - The shift kind field selects rotate left/right, through-carry rotates, logical and arithmetic right.
// - Opcode 001000dw conjoins register and register/memory, d picks destination, 3 or 10 cycles.
// - First byte 1000000w with data applies and/or/xor chosen by the middle field, 4 or 16 cycles.
// - Opcode 0010010w conjoins data with the accumulator, second data byte only for w=1, 3 or 4 cycles.
// - The register/memory test sets flags from the conjunction with no result, 3 or 10 cycles.
// - First byte 1111011w: middle 000 tests against data in 4 or 10 cycles, 010 inverts in 3 cycles.
// - Opcode 1010100w tests data against the accumulator with no result, 3 or 4 cycles.
// - Opcode 000010dw disjoins register and register/memory, d picks destination, 3 or 10 cycles.
// - Opcode 0000110w disjoins data into the accumulator, word width fetches two bytes, 3 or 4 cycles.
// - Opcode 001100dw exclusive-disjoins register and register/memory, 3 or 10 cycles.
// - Opcode 0011010w exclusive-disjoins data into the accumulator, 3 or 4 cycles.
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
// ***************************************************
// instruction fields
// ***************************************************
`define LSD_OPC7_FLD 7:1
`define LSD_OPC6_FLD 7:2
`define LSD_MOD_FLD 7:6
`define LSD_REG_FLD 5:3
`define LSD_RM_FLD 2:0
`define LSD_W_BIT 0
`define LSD_D_BIT 1
`define LSD_LO_BYTE 7:0
`define LSD_HI_BYTE 15:8
// ***************************************************
// opcode patterns
// ***************************************************
`define LSD_OPC_SH_ONE 7'h68
`define LSD_OPC_SH_CNT 7'h69
`define LSD_OPC_SH_IMM 7'h60
`define LSD_OPC_GRP_IMM 7'h40
`define LSD_OPC_TEST_RM 7'h42
`define LSD_OPC_GRP_UN 7'h7b
`define LSD_OPC_AND_ACC 7'h12
`define LSD_OPC_OR_ACC 7'h06
`define LSD_OPC_XOR_ACC 7'h1a
`define LSD_OPC_TEST_ACC 7'h54
`define LSD_OPC_AND_RM 6'h08
`define LSD_OPC_OR_RM 6'h02
`define LSD_OPC_XOR_RM 6'h0c
`define LSD_GRP_AND 3'h4
`define LSD_GRP_OR 3'h1
`define LSD_GRP_XOR 3'h6
`define LSD_UN_TEST 3'h0
`define LSD_UN_NOT 3'h2
`define LSD_KIND_ROL 3'h0
`define LSD_KIND_ROR 3'h1
`define LSD_KIND_RCL 3'h2
`define LSD_KIND_RCR 3'h3
`define LSD_KIND_SHR 3'h5
`define LSD_KIND_SAR 3'h7
`define LSD_MOD_REG 2'h3
`define LSD_MOD_NODISP 2'h0
`define LSD_MOD_D8 2'h1
`define LSD_MOD_D16 2'h2
`define LSD_RM_DIRECT 3'h6
// ***************************************************
// cycle costs
// ***************************************************
`define LSD_CYC_SH1_REG 9'h002
`define LSD_CYC_SH1_MEM 9'h00f
`define LSD_CYC_SHN_REG 9'h005
`define LSD_CYC_SHN_MEM 9'h011
`define LSD_CYC_RM_REG 9'h003
`define LSD_CYC_RM_MEM 9'h00a
`define LSD_CYC_IMM_REG 9'h004
`define LSD_CYC_IMM_MEM 9'h010
`define LSD_CYC_TSTI_MEM 9'h00a
`define LSD_CYC_ACC_B 9'h003
`define LSD_CYC_ACC_W 9'h004
`define LSD_CYC_NOT 9'h003
`define LSD_CYC_LAST 9'h001
`define LSD_LEFT_ONE 2'h1
`define LSD_LEFT_TWO 2'h2
`define LSD_LEFT_NONE 2'h0
`endif

// [src/lsd_pkg.sv]
package lsd_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_SHIFT = 3'h1, OP_AND = 3'h2, OP_OR = 3'h3,
        OP_XOR = 3'h4, OP_TEST = 3'h5, OP_NOT = 3'h6
    } lsd_op_t;
    typedef enum logic [2:0] {
        FORM_REG_RM = 3'h0, FORM_IMM_RM = 3'h1, FORM_ACC = 3'h2, FORM_SH_ONE = 3'h3,
        FORM_SH_CNT = 3'h4, FORM_SH_IMM = 3'h5, FORM_UNARY = 3'h6
    } lsd_form_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01, ST_MODRM = 6'h02, ST_DISP = 6'h04,
        ST_IMM = 6'h08, ST_LOAD = 6'h10, ST_EXEC = 6'h20
    } lsd_state_t;
endpackage

// [src/lsd_dec_if.sv]
`timescale 1ns/100ps
interface lsd_dec_if;
    import lsd_pkg::*;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] n;
    lsd_op_t op;
    lsd_form_t form;
    logic known;
    logic needs_modrm;
    logic illegal_mid;
    logic [1:0] imm_bytes;
    logic dir_to_reg;
    logic mem;
    logic [8:0] cycles;
    modport dec (input opcode, modrm, output op, form, known, needs_modrm, illegal_mid,
        imm_bytes, dir_to_reg);
    modport calc (input op, form, opcode, mem, n, output cycles);
    modport top (output opcode, modrm, n, mem, input op, form, known, needs_modrm,
        illegal_mid, imm_bytes, dir_to_reg, cycles);
endinterface

// [src/lsd_field_decode.sv]
`timescale 1ns/100ps
`include "lsd_defs.svh"
module lsd_field_decode
    import lsd_pkg::*;
(
    lsd_dec_if.dec d
);
    // ***************************************************
    // opcode match
    // ***************************************************
    wire [6:0] o7 = d.opcode[`LSD_OPC7_FLD];
    wire [5:0] o6 = d.opcode[`LSD_OPC6_FLD];
    wire [2:0] mid = d.modrm[`LSD_REG_FLD];
    wire is_sh1 = o7 == `LSD_OPC_SH_ONE;
    wire is_shc = o7 == `LSD_OPC_SH_CNT;
    wire is_shi = o7 == `LSD_OPC_SH_IMM;
    wire is_and_rm = o6 == `LSD_OPC_AND_RM;
    wire is_or_rm = o6 == `LSD_OPC_OR_RM;
    wire is_xor_rm = o6 == `LSD_OPC_XOR_RM;
    wire is_grpi = o7 == `LSD_OPC_GRP_IMM;
    wire is_test_rm = o7 == `LSD_OPC_TEST_RM;
    wire is_grpu = o7 == `LSD_OPC_GRP_UN;
    wire is_and_acc = o7 == `LSD_OPC_AND_ACC;
    wire is_or_acc = o7 == `LSD_OPC_OR_ACC;
    wire is_xor_acc = o7 == `LSD_OPC_XOR_ACC;
    wire is_test_acc = o7 == `LSD_OPC_TEST_ACC;
    wire is_shift = is_sh1 | is_shc | is_shi;
    wire is_rm = is_and_rm | is_or_rm | is_xor_rm;
    wire is_acc = is_and_acc | is_or_acc | is_xor_acc | is_test_acc;
    // ***************************************************
    // middle field
    // ***************************************************
    wire kind_ok = mid == `LSD_KIND_ROL || mid == `LSD_KIND_ROR || mid == `LSD_KIND_RCL ||
        mid == `LSD_KIND_RCR || mid == `LSD_KIND_SHR || mid == `LSD_KIND_SAR;
    wire gi_and = is_grpi && mid == `LSD_GRP_AND;
    wire gi_or = is_grpi && mid == `LSD_GRP_OR;
    wire gi_xor = is_grpi && mid == `LSD_GRP_XOR;
    wire gu_test = is_grpu && mid == `LSD_UN_TEST;
    wire gu_not = is_grpu && mid == `LSD_UN_NOT;
    wire word = d.opcode[`LSD_W_BIT];
    assign d.known = is_shift | is_rm | is_grpi | is_test_rm | is_grpu | is_acc;
    assign d.needs_modrm = is_shift | is_rm | is_grpi | is_test_rm | is_grpu;
    assign d.illegal_mid = (is_shift & ~kind_ok) | (is_grpi & ~(gi_and | gi_or | gi_xor)) |
        (is_grpu & ~(gu_test | gu_not));
    assign d.op = is_shift ? OP_SHIFT :
        (is_and_rm | is_and_acc | gi_and) ? OP_AND :
        (is_or_rm | is_or_acc | gi_or) ? OP_OR :
        (is_xor_rm | is_xor_acc | gi_xor) ? OP_XOR :
        (is_test_rm | is_test_acc | gu_test) ? OP_TEST :
        gu_not ? OP_NOT : OP_NONE;
    assign d.form = is_sh1 ? FORM_SH_ONE : is_shc ? FORM_SH_CNT : is_shi ? FORM_SH_IMM :
        (is_rm | is_test_rm) ? FORM_REG_RM : (is_grpi | gu_test) ? FORM_IMM_RM :
        gu_not ? FORM_UNARY : FORM_ACC;
    // second data byte only for word width
    assign d.imm_bytes = is_shi ? `LSD_LEFT_ONE :
        (is_grpi | gu_test | is_acc) ? (word ? `LSD_LEFT_TWO : `LSD_LEFT_ONE) :
        `LSD_LEFT_NONE;
    assign d.dir_to_reg = is_rm & d.opcode[`LSD_D_BIT];
endmodule // lsd_field_decode

// [src/lsd_cycle_calc.sv]
`timescale 1ns/100ps
`include "lsd_defs.svh"
module lsd_cycle_calc
    import lsd_pkg::*;
(
    lsd_dec_if.calc c
);
    // ***************************************************
    // clock cost per form
    // ***************************************************
    wire word = c.opcode[`LSD_W_BIT];
    wire [8:0] n9 = {1'b0, c.n};
    wire [8:0] sh1 = c.mem ? `LSD_CYC_SH1_MEM : `LSD_CYC_SH1_REG;
    wire [8:0] shn = (c.mem ? `LSD_CYC_SHN_MEM : `LSD_CYC_SHN_REG) + n9;
    wire [8:0] rm = c.mem ? `LSD_CYC_RM_MEM : `LSD_CYC_RM_REG;
    wire [8:0] imm_logic = c.mem ? `LSD_CYC_IMM_MEM : `LSD_CYC_IMM_REG;
    wire [8:0] imm_test = c.mem ? `LSD_CYC_TSTI_MEM : `LSD_CYC_IMM_REG;
    wire [8:0] acc = word ? `LSD_CYC_ACC_W : `LSD_CYC_ACC_B;
    assign c.cycles = (c.form == FORM_SH_ONE) ? sh1 :
        (c.form == FORM_SH_CNT || c.form == FORM_SH_IMM) ? shn :
        (c.form == FORM_REG_RM) ? rm :
        (c.form == FORM_IMM_RM) ? ((c.op == OP_TEST) ? imm_test : imm_logic) :
        (c.form == FORM_ACC) ? acc : `LSD_CYC_NOT;
endmodule // lsd_cycle_calc

// [bench/lsd_top_tb.sv]
`timescale 1ns/100ps
module lsd_top_tb;
    import lsd_pkg::*;
    logic i_core_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b0, i_byte_valid = 1'b0;
    logic [7:0] i_byte = 8'h00, i_shift_count = 8'h00;
    logic o_byte_ready, o_valid, o_done, o_busy, o_illegal, o_word, o_dir_to_reg, o_mem;
    logic o_write_result, o_flags_only;
    lsd_op_t o_op;
    lsd_form_t o_form;
    logic [2:0] o_shift_kind, o_reg_field, o_rm_field;
    logic [15:0] o_disp, o_imm;
    logic [7:0] o_shift_amount;
    logic [8:0] o_cycles;
    int num_errors = 0, n_checks = 0;
    logic ce_last = 1'b1;
    bit ce_rand = 1'b0;
    logic [7:0] q[$];
    lsd_top i_dut (.i_core_clk, .i_rstn, .i_ce, .i_byte_valid, .i_byte, .i_shift_count,
        .o_byte_ready, .o_valid, .o_done, .o_busy, .o_illegal, .o_op, .o_form, .o_shift_kind,
        .o_word, .o_dir_to_reg, .o_mem, .o_write_result, .o_flags_only, .o_reg_field,
        .o_rm_field, .o_disp, .o_imm, .o_shift_amount, .o_cycles);
    always #50 i_core_clk = ~i_core_clk;
    // ***************************************************
    // helpers
    // ***************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick();
        @(negedge i_core_clk);
        ce_last = i_ce;
        i_ce = ce_rand ? ($urandom % 4 != 0) : 1'b1;
    endtask
    // offer the queued bytes, then drop valid at the following falling edge
    task automatic send();
        int g;
        foreach (q[i]) begin
            g = 0;
            @(negedge i_core_clk);
            i_ce = 1'b1;
            i_byte = q[i];
            i_byte_valid = 1'b1;
            while (o_byte_ready !== 1'b1) begin
                @(negedge i_core_clk);
                g++;
                if (g > 400) begin
                    check(16'h0, 16'h1);
                    conclude();
                end
            end
        end
        @(negedge i_core_clk);
        i_byte_valid = 1'b0;
    endtask
    task automatic ill(input logic [7:0] a, input logic [7:0] b, input bit two);
        q = {a};
        if (two) q.push_back(b);
        send();
        check({15'h0, o_illegal}, 16'h1);
    endtask
    // ***************************************************
    // one instruction: build, send, compare fields and timing
    // ***************************************************
    task automatic run(input int k, input int j);
        logic [7:0] rmop[3] = '{8'h20, 8'h08, 8'h30};
        logic [7:0] accop[4] = '{8'h24, 8'h0c, 8'h34, 8'ha8};
        lsd_op_t lop[4] = '{OP_AND, OP_OR, OP_XOR, OP_TEST};
        logic [2:0] gm[3] = '{3'h4, 3'h1, 3'h6};
        logic [2:0] kd[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
        lsd_form_t efs[9] = '{FORM_SH_ONE, FORM_SH_CNT, FORM_SH_IMM, FORM_REG_RM, FORM_IMM_RM,
            FORM_ACC, FORM_REG_RM, FORM_IMM_RM, FORM_UNARY};
        logic w, d, mem, has_rm, busy_ok;
        logic [1:0] md;
        logic [2:0] mid, rm;
        logic [7:0] n, lo, hi, dl, dh, opc;
        int nd, ni, g, cnt;
        lsd_op_t eop;
        lsd_form_t ef;
        logic [8:0] base, memc, ecyc;
        w = $urandom % 2;
        d = $urandom % 2;
        md = $urandom % 4;
        rm = $urandom % 8;
        mid = $urandom % 8;
        {lo, hi, dl, dh} = $urandom;
        n = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($urandom % 256);
        i_shift_count = n;
        has_rm = 1'b1;
        ni = (k == 4 || k == 5 || k == 7) ? 1 + w : 0;
        eop = (k == 5) ? lop[j % 4] : (k > 5) ? OP_TEST : lop[j % 3];
        ef = efs[k];
        base = 9'h003;
        memc = 9'h00a;
        case (k)
            0: {opc, base, memc} = {8'hd0, 9'h002, 9'h00f};
            1: opc = 8'hd2;
            2: opc = 8'hc0;
            3: opc = rmop[j % 3] | {6'h0, d, 1'b0};
            4: {opc, mid, base, memc} = {8'h80, gm[j % 3], 9'h004, 9'h010};
            5: {opc, has_rm} = {accop[j % 4], 1'b0};
            6: opc = 8'h84;
            7: {opc, mid, base} = {8'hf6, 3'h0, 9'h004};
            default: {opc, mid, memc} = {8'hf6, 3'h2, 9'h003};
        endcase
        if (k < 3) mid = kd[j];
        if (k < 3) eop = OP_SHIFT;
        if (k > 7) eop = OP_NOT;
        if (k == 1 || k == 2) {base, memc} = {9'h005 + n, 9'h011 + n};
        if (k == 5) base = w ? 9'h004 : 9'h003;
        opc[0] = w;
        mem = has_rm && md != 2'h3;
        nd = !has_rm ? 0 : (md == 2'h1) ? 1 : (md == 2'h2 || (md == 2'h0 && rm == 3'h6)) ? 2 : 0;
        ecyc = mem ? memc : base;
        q = {opc};
        if (has_rm) q.push_back({md, mid, rm});
        if (nd > 0) q.push_back(dl);
        if (nd > 1) q.push_back(dh);
        if (k == 2) q.push_back(n);
        if (ni > 0) q.push_back(lo);
        if (ni > 1) q.push_back(hi);
        send();
        ce_rand = 1'b1;
        g = 0;
        do begin
            tick();
            g++;
            if (g > 1000) begin
                check(16'h0, 16'h1);
                conclude();
            end
        end while (!(ce_last && o_valid === 1'b1));
        check({13'h0, o_op}, {13'h0, eop});
        check({13'h0, o_form}, {13'h0, ef});
        check({15'h0, o_word}, {15'h0, w});
        check({15'h0, o_dir_to_reg}, {15'h0, d && k == 3});
        check({15'h0, o_flags_only}, {15'h0, eop == OP_TEST});
        check({15'h0, o_write_result}, {15'h0, eop != OP_TEST});
        check(16'(o_cycles), 16'(ecyc));
        if (has_rm) check({9'h0, o_mem, o_reg_field, o_rm_field}, {9'h0, mem, mid, rm});
        if (k < 3) check(16'(o_shift_kind), 16'(mid));
        if (k == 1 || k == 2) check(16'(o_shift_amount), 16'(n));
        if (ni > 0) check(o_imm, (ni == 2) ? {hi, lo} : {8'h00, lo});
        if (k == 2) check(16'(o_imm[7:0]), 16'(n));
        if (nd > 0) check(16'(o_disp[7:0]), 16'(dl));
        if (nd > 1) check(o_disp, {dh, dl});
        cnt = 1;
        busy_ok = 1'b1;
        forever begin
            tick();
            g++;
            if (g > 1000) begin
                check(16'h0, 16'h1);
                conclude();
            end
            if (ce_last && o_done === 1'b1) break;
            if (ce_last) begin
                busy_ok = busy_ok && o_busy === 1'b1 && o_byte_ready === 1'b0;
                cnt++;
            end
        end
        check({13'h0, busy_ok, o_busy, o_byte_ready}, 16'h5);
        check(16'(cnt), 16'(ecyc));
        ce_rand = 1'b0;
    endtask
    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        void'($urandom(59520));
        repeat (12) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rstn = 1'b1;
        i_ce = 1'b1;
        ill(8'ha4, 8'h00, 1'b0);
        ill(8'hd0, 8'he0, 1'b1);
        ill(8'hf6, 8'hc8, 1'b1);
        for (int k = 0; k < 9; k++) begin
            for (int j = 0; j < 6; j++) begin
                run(k, j);
            end
        end
        repeat (60) run($urandom % 9, $urandom % 6);
        conclude();
    end
endmodule // lsd_top_tb
